// ---- shared/dcc_defines.svh ----
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH
// Control field positions inside each comparator control byte
`define DCC_CTL_CHSEL_LO  0
`define DCC_CTL_CHSEL_HI  1
`define DCC_CTL_REFSEL    2
`define DCC_CTL_SPEED     3
`define DCC_CTL_POL       4
`define DCC_CTL_PINOE     5
`define DCC_CTL_RESULT    6
`define DCC_CTL_ENABLE    7
// Reset values
`define DCC_RST_SPEED     1'h1
`define DCC_RST_CTL       8'h08
`define DCC_RST_INVSEL    4'h1
// Instruction cycle: four system clocks
`define DCC_CYC_DIV       4
`define DCC_CYC_W         2
`endif

// ---- shared/dcc_pkg.sv ----
package dcc_pkg;
  typedef logic [1:0] dcc_chsel_t;
  // Inverting input source, one-hot on the analog mux
  typedef enum logic [3:0] {
    DCC_INV_SRC0 = 4'h1,
    DCC_INV_SRC1 = 4'h2,
    DCC_INV_SRC2 = 4'h4,
    DCC_INV_SRC3 = 4'h8
  } dcc_invsel_e;
  // Shared pin source
  typedef enum logic [2:0] {
    DCC_PIN_PORT = 3'h1,
    DCC_PIN_C1   = 3'h2,
    DCC_PIN_C2   = 3'h4
  } dcc_pinsrc_e;
endpackage : dcc_pkg

// ---- logic/dcc_comparators.sv ----
// What this block does
// - Result high when non-inverting above inverting
// - Enable bit runs comparator, clear powers down
// - Two-bit field picks one of four inputs
// - Reference bit picks non-inverting source
// - Results readable per comparator and mirrored
// - Comparator drives pin only with enables and direction
// - Pin priority: comparator two, comparator one, port
// - Output enable overrides port latch
// - Internal result latched each instruction cycle
// - Polarity bit inverts reported result
// - Speed bit resets high, zero is low-power
// - Both comparators have auxiliary mirror register bits
// - Reference one selects internal reference output
// - Disabled comparator output follows polarity bit
// - Reset turns comparators and references off
`include "dcc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module dcc_comparators (
  input  wire logic       mclk_in,          // 200 MHz clock
  input  wire logic       arst_n_in,        // Async reset, active low
  input  wire logic [1:0] comp_enable_in,   // Per-comparator enable
  input  wire logic [3:0] inv_input_select_in, // {c2,c1} 2-bit fields
  input  wire logic [1:0] noninv_ref_select_in, // 1 internal reference
  input  wire logic [1:0] result_invert_in, // Polarity per comparator
  input  wire logic [1:0] speed_power_select_in, // 1 high speed
  input  wire logic       comp1_pin_enable_in, // Comparator 1 to pin
  input  wire logic       comp2_pin_enable_in, // Comparator 2 to pin
  input  wire logic       pin_direction_in, // 0 output, 1 input
  input  wire logic       port_data_in,     // Port data latch value
  input  wire logic [1:0] analog_cmp_in,    // Raw analog compare, async
  output logic [1:0]      comp_result_bit_out, // Latched results
  output logic [1:0]      mirrored_result_bit_out, // Aux-register copy
  output logic [7:0]      comp1_control_out, // Control readback c1
  output logic [7:0]      comp2_control_out, // Control readback c2
  output logic [1:0]      comp_power_on_out, // Analog core bias on
  output logic [1:0]      low_power_mode_out, // Analog low-power mode
  output logic [1:0]      ref_power_on_out, // Reference needed on
  output logic [3:0]      c1_inv_mux_out,   // One-hot inverting mux
  output logic [3:0]      c2_inv_mux_out,   // One-hot inverting mux
  output logic [1:0]      noninv_mux_out,   // 1 internal ref, 0 pin
  output logic            shared_result_pin_out, // Pin output value
  output logic            shared_result_pin_oe_n_out // Low while driven
);

  function automatic dcc_pkg::dcc_invsel_e dec_inv(
    input dcc_pkg::dcc_chsel_t sel
  );
    case (sel)
      2'h0:    dec_inv = dcc_pkg::DCC_INV_SRC0;
      2'h1:    dec_inv = dcc_pkg::DCC_INV_SRC1;
      2'h2:    dec_inv = dcc_pkg::DCC_INV_SRC2;
      default: dec_inv = dcc_pkg::DCC_INV_SRC3;
    endcase
  endfunction : dec_inv

  logic [1:0]            sync1_reg;
  logic [1:0]            sync2_reg;
  logic [`DCC_CYC_W-1:0] cyc_cnt_reg;
  logic                  cyc_en;
  logic [1:0]            cmp_pol;
  logic [1:0]            result_reg;
  logic [1:0]            result_next;
  logic                  pin_reg;
  logic                  pin_oe_n_reg;
  logic                  pin_next;
  logic                  pin_oe_n_next;
  dcc_pkg::dcc_pinsrc_e  pin_src;
  logic [3:0]            inv1_next;
  logic [3:0]            inv2_next;

  // Every check below runs on mclk and rests while reset is held
  default clocking cb_mclk @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);

  // Two stages because the compare edge is unrelated to mclk
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
    end else begin
      sync1_reg <= analog_cmp_in;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cyc_cnt_reg <= '0;
    end else begin
      cyc_cnt_reg <= cyc_cnt_reg + 1'b1;
    end
  end
  assign cyc_en = (cyc_cnt_reg == `DCC_CYC_W'(`DCC_CYC_DIV - 1));

  // Polarity applied; disabled comparator reads as its polarity bit
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cmp
      assign cmp_pol[g] = comp_enable_in[g] ?
                          (sync2_reg[g] ^ result_invert_in[g])
                          : result_invert_in[g];
      assign result_next[g] = cyc_en ? cmp_pol[g] : result_reg[g];
    end
  endgenerate

  // Pin path skips the cycle latch so it follows within clocks
  assign pin_src = comp2_pin_enable_in ? dcc_pkg::DCC_PIN_C2 :
                   comp1_pin_enable_in ? dcc_pkg::DCC_PIN_C1 :
                                         dcc_pkg::DCC_PIN_PORT;
  always_comb begin
    case (pin_src)
      dcc_pkg::DCC_PIN_C2: begin
        pin_next      = cmp_pol[1];
        pin_oe_n_next = !(comp_enable_in[1] && !pin_direction_in);
      end
      dcc_pkg::DCC_PIN_C1: begin
        pin_next      = cmp_pol[0];
        pin_oe_n_next = !(comp_enable_in[0] && !pin_direction_in);
      end
      default: begin
        pin_next      = port_data_in;
        pin_oe_n_next = pin_direction_in;
      end
    endcase
  end

  assign inv1_next = dec_inv(inv_input_select_in[1:0]);
  assign inv2_next = dec_inv(inv_input_select_in[3:2]);

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      result_reg              <= 2'h0;
      comp_result_bit_out     <= 2'h0;
      mirrored_result_bit_out <= 2'h0;
      pin_reg                 <= 1'h0;
      pin_oe_n_reg            <= 1'h1;
      comp_power_on_out       <= 2'h0;
      low_power_mode_out      <= {2{~`DCC_RST_SPEED}};
      ref_power_on_out        <= 2'h0;
      c1_inv_mux_out          <= `DCC_RST_INVSEL;
      c2_inv_mux_out          <= `DCC_RST_INVSEL;
      noninv_mux_out          <= 2'h0;
      comp1_control_out       <= `DCC_RST_CTL;
      comp2_control_out       <= `DCC_RST_CTL;
    end else begin
      result_reg              <= result_next;
      comp_result_bit_out     <= result_next;
      mirrored_result_bit_out <= result_next;
      pin_reg                 <= pin_next;
      pin_oe_n_reg            <= pin_oe_n_next;
      comp_power_on_out       <= comp_enable_in;
      low_power_mode_out      <= ~speed_power_select_in;
      ref_power_on_out        <= comp_enable_in & noninv_ref_select_in;
      c1_inv_mux_out          <= inv1_next;
      c2_inv_mux_out          <= inv2_next;
      noninv_mux_out          <= noninv_ref_select_in;
      comp1_control_out       <= {comp_enable_in[0], result_next[0],
                                  comp1_pin_enable_in, result_invert_in[0],
                                  speed_power_select_in[0],
                                  noninv_ref_select_in[0],
                                  inv_input_select_in[1:0]};
      comp2_control_out       <= {comp_enable_in[1], result_next[1],
                                  comp2_pin_enable_in, result_invert_in[1],
                                  speed_power_select_in[1],
                                  noninv_ref_select_in[1],
                                  inv_input_select_in[3:2]};
    end
  end
  assign shared_result_pin_out      = pin_reg;
  assign shared_result_pin_oe_n_out = pin_oe_n_reg;

  chk_pin_priority: assert property (
    (comp2_pin_enable_in && comp_enable_in[1] && !pin_direction_in)
    |=> (!shared_result_pin_oe_n_out
         && shared_result_pin_out == $past(cmp_pol[1])))
    else $error("pin not carrying comparator two");
  chk_pin_c1: assert property (
    (comp1_pin_enable_in && !comp2_pin_enable_in && comp_enable_in[0]
     && !pin_direction_in)
    |=> (!shared_result_pin_oe_n_out
         && shared_result_pin_out
            == $past(sync2_reg[0] ^ result_invert_in[0])))
    else $error("pin not carrying comparator one");
  chk_pin_gate: assert property (
    pin_direction_in |=> shared_result_pin_oe_n_out)
    else $error("pin driven while direction is input");
  chk_c2_gate: assert property (
    (comp2_pin_enable_in && !comp_enable_in[1])
    |=> shared_result_pin_oe_n_out)
    else $error("pin driven by disabled comparator two");
  chk_port_data: assert property (
    (!comp1_pin_enable_in && !comp2_pin_enable_in)
    |=> shared_result_pin_out == $past(port_data_in))
    else $error("port data not on pin");
  chk_port_oe: assert property (
    (!comp1_pin_enable_in && !comp2_pin_enable_in)
    |=> shared_result_pin_oe_n_out == $past(pin_direction_in))
    else $error("port direction not on pin enable");
  chk_disabled_pol: assert property (
    (cyc_en && !comp_enable_in[0])
    |=> comp_result_bit_out[0] == $past(result_invert_in[0]))
    else $error("disabled result not polarity");
  chk_hold_cycle: assert property (
    !cyc_en |=> $stable(result_reg))
    else $error("result changed mid cycle");
  chk_sync_path: assert property (
    (cyc_en && comp_enable_in[1] && !result_invert_in[1])
    |=> comp_result_bit_out[1] == $past(analog_cmp_in[1], 3))
    else $error("sync or compare result wrong");
  chk_mirror_eq: assert property (
    mirrored_result_bit_out == comp_result_bit_out)
    else $error("mirror differs");
  chk_speed_map: assert property (
    1'h1 |=> low_power_mode_out == ~$past(speed_power_select_in))
    else $error("speed mode wrong");
  chk_power_map: assert property (
    1'h1 |=> comp_power_on_out == $past(comp_enable_in))
    else $error("power state wrong");
  chk_inv_map: assert property (
    1'h1 |=> (c1_inv_mux_out == 4'h1 << $past(inv_input_select_in[1:0])
              && c2_inv_mux_out == 4'h1 << $past(inv_input_select_in[3:2])))
    else $error("inverting mux select wrong");
  chk_ref_power: assert property (
    1'h1 |=> ref_power_on_out
             == $past(comp_enable_in & noninv_ref_select_in))
    else $error("reference power wrong");

endmodule : dcc_comparators
`default_nettype wire

// ---- bench/dcc_analog_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module dcc_analog_model (
  input  wire logic        mclk_in,        // Paces idle core output
  input  wire logic [3:0]  c1_inv_mux_in,  // One-hot inverting source
  input  wire logic [3:0]  c2_inv_mux_in,  // One-hot inverting source
  input  wire logic [1:0]  noninv_mux_in,  // 1 internal reference
  input  wire logic [1:0]  power_on_in,    // Core bias on
  input  wire logic [31:0] inv_lvl_in,     // Four inverting levels
  input  wire logic [15:0] pin_lvl_in,     // Non-inverting pin levels
  input  wire logic [7:0]  ref_lvl_in,     // Internal reference level
  output logic      [1:0]  analog_cmp_out  // 1 when plus above minus
);
  logic [7:0] minus_1, minus_2, plus_1, plus_2;
  logic [1:0] idle_reg = 2'h0;
  function automatic logic [7:0] pick(input logic [3:0] oh,
                                      input logic [31:0] lv);
    pick = 8'h00;
    for (int k = 0; k < 4; k++) if (oh[k]) pick = lv[8*k +: 8];
  endfunction : pick
  assign minus_1 = pick(c1_inv_mux_in, inv_lvl_in);
  assign minus_2 = pick(c2_inv_mux_in, inv_lvl_in);
  assign plus_1  = noninv_mux_in[0] ? ref_lvl_in : pin_lvl_in[7:0];
  assign plus_2  = noninv_mux_in[1] ? ref_lvl_in : pin_lvl_in[15:8];
  // A powered-down core gives nothing useful, so it keeps changing
  always @(posedge mclk_in) idle_reg <= ~idle_reg;
  assign analog_cmp_out[0] = power_on_in[0] ? (plus_1 > minus_1)
                                            : idle_reg[0];
  assign analog_cmp_out[1] = power_on_in[1] ? (plus_2 > minus_2)
                                            : idle_reg[1];
endmodule : dcc_analog_model
`default_nettype wire

// ---- bench/dual_comparator_control_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module dual_comparator_control_bench;
  typedef struct packed {
    logic [1:0] en; logic [3:0] sel; logic [1:0] rf; logic [1:0] pol;
    logic oe1; logic oe2; logic dir; logic port;
    logic [1:0] res; logic pin; logic oe_n;
  } dcc_row_s;
  logic       mclk_in = 1'b0;
  logic       arst_n_in = 1'b0;
  logic [1:0] en, rf, pol, sp, res, mir, pwr, lpm, rpw, nmux, acmp;
  logic [3:0] sel, m1, m2;
  logic       oe1, oe2, dir, port, pin, oe_n;
  logic [7:0] ctl1, ctl2, exp1, exp2;
  int         errors = 0;
  int         check_count = 0;
  dcc_row_s   rows [8];
  always #2.5 mclk_in = ~mclk_in;
  dcc_comparators u_dcc_comparators (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .comp_enable_in(en), .inv_input_select_in(sel), .noninv_ref_select_in(rf),
    .result_invert_in(pol), .speed_power_select_in(sp),
    .comp1_pin_enable_in(oe1), .comp2_pin_enable_in(oe2),
    .pin_direction_in(dir), .port_data_in(port), .analog_cmp_in(acmp),
    .comp_result_bit_out(res), .mirrored_result_bit_out(mir),
    .comp1_control_out(ctl1), .comp2_control_out(ctl2),
    .comp_power_on_out(pwr), .low_power_mode_out(lpm), .ref_power_on_out(rpw),
    .c1_inv_mux_out(m1), .c2_inv_mux_out(m2), .noninv_mux_out(nmux),
    .shared_result_pin_out(pin), .shared_result_pin_oe_n_out(oe_n));
  dcc_analog_model u_dcc_analog_model (.mclk_in(mclk_in), .c1_inv_mux_in(m1),
    .c2_inv_mux_in(m2), .noninv_mux_in(nmux), .power_on_in(pwr),
    .inv_lvl_in(32'h32c86400), .pin_lvl_in(16'h9696), .ref_lvl_in(8'h78),
    .analog_cmp_out(acmp));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    rows[0] = '{2'h3,4'h4,2'h0,2'h0,1'b0,1'b0,1'b0,1'b1,2'h3,1'b1,1'b0};
    rows[1] = '{2'h3,4'he,2'h0,2'h0,1'b1,1'b0,1'b0,1'b1,2'h2,1'b0,1'b0};
    rows[2] = '{2'h3,4'he,2'h0,2'h3,1'b1,1'b1,1'b0,1'b1,2'h1,1'b0,1'b0};
    rows[3] = '{2'h3,4'h9,2'h3,2'h2,1'b0,1'b1,1'b0,1'b0,2'h3,1'b1,1'b0};
    rows[4] = '{2'h0,4'h9,2'h3,2'h2,1'b1,1'b0,1'b0,1'b1,2'h2,1'b0,1'b1};
    rows[5] = '{2'h1,4'h4,2'h0,2'h0,1'b0,1'b1,1'b0,1'b1,2'h1,1'b0,1'b1};
    rows[6] = '{2'h3,4'h4,2'h0,2'h0,1'b1,1'b0,1'b1,1'b1,2'h3,1'b0,1'b1};
    rows[7] = '{2'h0,4'h4,2'h0,2'h0,1'b0,1'b0,1'b1,1'b0,2'h0,1'b0,1'b1};
    {en, sel, rf, pol, oe1, oe2, dir, port} = rows[0][17:4];
    sp = 2'h3;
    repeat (5) @(negedge mclk_in);
    check(ctl1, 8'h08);
    check({6'h0, res}, 8'h00);
    check({7'h0, oe_n}, 8'h01);
    check({4'h0, m1}, 8'h01);
    check({6'h0, pwr}, 8'h00);
    check({6'h0, rpw}, 8'h00);
    check({6'h0, lpm}, 8'h00);
    arst_n_in = 1'h1;
    // Results are latched once per instruction cycle, not every clock
    repeat (3) @(negedge mclk_in);
    check({6'h0, res}, 8'h00);
    repeat (2) @(negedge mclk_in);
    check({6'h0, res}, 8'h03);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      {en, sel, rf, pol, oe1, oe2, dir, port} = rows[i][17:4];
      sp = i[1:0];
      // Ten clocks cover sync, the cycle latch and the core response
      repeat (10) @(negedge mclk_in);
      check({6'h0, res}, {6'h0, rows[i].res});
      check({6'h0, mir}, {6'h0, rows[i].res});
      check({7'h0, oe_n}, {7'h0, rows[i].oe_n});
      if (!rows[i].oe_n || !(oe1 | oe2)) begin
        check({7'h0, pin}, {7'h0, rows[i].pin});
      end
      exp1 = {en[0], rows[i].res[0], oe1, pol[0], sp[0], rf[0], sel[1:0]};
      exp2 = {en[1], rows[i].res[1], oe2, pol[1], sp[1], rf[1], sel[3:2]};
      check(ctl1, exp1);
      check(ctl2, exp2);
      check({6'h0, pwr}, {6'h0, en});
      check({6'h0, lpm}, {6'h0, ~sp});
      check({6'h0, rpw}, {6'h0, en & rf});
      check({4'h0, m1}, {4'h0, 4'h1 << sel[1:0]});
      check({4'h0, m2}, {4'h0, 4'h1 << sel[3:2]});
      check({6'h0, nmux}, {6'h0, rf});
      $display("test %0d done", i);
    end
    // Pin path skips the cycle latch, so it follows polarity in one clock
    {en, sel, rf, pol} = {2'h3, 4'h4, 2'h0, 2'h0};
    {oe1, oe2, dir, port} = 4'h4;
    repeat (10) @(negedge mclk_in);
    check({6'h0, res}, 8'h03);
    check({7'h0, pin}, 8'h01);
    pol = 2'h2;
    @(negedge mclk_in);
    check({7'h0, pin}, 8'h00);
    check({7'h0, oe_n}, 8'h00);
    repeat (5) @(negedge mclk_in);
    check({6'h0, res}, 8'h01);
    $display("test pin bypass done");
    arst_n_in = 1'h0;
    #1;
    check(ctl2, 8'h08);
    check({6'h0, rpw}, 8'h00);
    check({6'h0, mir}, 8'h00);
    check({7'h0, oe_n}, 8'h01);
    @(negedge mclk_in);
    arst_n_in = 1'h1;
    repeat (2) @(negedge mclk_in);
    check({6'h0, res}, 8'h00);
    check({6'h0, pwr}, 8'h03);
    $display("test second reset done");
    print_verdict();
  end
endmodule : dual_comparator_control_bench
`default_nettype wire
